/* pkg/xcr_pkg.sv */
package xcr_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // capability space byte offsets
  localparam logic [15:0] CAPLEN_OFF = 16'h0000;
  localparam logic [15:0] CAP_PARAMS_OFF = 16'h0010;
  localparam logic [15:0] DOORBELL_OFF = 16'h0014;
  localparam logic [15:0] RUNTIME_OFF = 16'h0018;

  // capability length value, the distance from the bank base to the operational base
  localparam logic [7:0] CAP_LENGTH = 8'h20;

  // capability parameters fields
  localparam logic [15:0] EXT_CAP_PTR = 16'h0270;
  localparam logic [3:0] MAX_PSA = 4'hf;
  localparam logic [1:0] CAP_RSVD = 2'h0;
  localparam logic SEC_BW_DOMAIN = 1'b0;
  localparam logic FORCE_STOP = 1'b0;
  localparam logic NO_SEC_SID = 1'b0;
  localparam logic LAT_TOL = 1'b1;
  localparam logic LIGHT_RESET = 1'b1;
  localparam logic PORT_IND = 1'b0;
  localparam logic CTX_SIZE_64 = 1'b1;
  localparam logic BW_NEG = 1'b0;
  localparam logic WIDE_ADDR = 1'b1;

  // fixed pointer words
  localparam logic [31:0] DOORBELL_VAL = 32'h0000_05c0;
  localparam logic [31:0] RUNTIME_VAL = 32'h0000_04a0;

  // operational offsets, relative to the operational base
  localparam logic [15:0] OP_USBCMD = 16'h0000;
  localparam logic [15:0] OP_USBSTS = 16'h0004;
  localparam logic [15:0] OP_PAGESIZE = 16'h0008;
  localparam logic [15:0] OP_DNCTRL = 16'h0014;
  localparam logic [15:0] OP_CRCR_LO = 16'h0018;
  localparam logic [15:0] OP_CRCR_HI = 16'h001c;
  localparam logic [15:0] OP_DCBAAP_LO = 16'h0030;
  localparam logic [15:0] OP_DCBAAP_HI = 16'h0034;
  localparam logic [15:0] OP_CONFIG = 16'h0038;
  localparam logic [15:0] OP_PORT_LO = 16'h0400;
  localparam logic [15:0] OP_PORT_HI = 16'h047f;

  // operational region selector handed to the register owners
  typedef enum logic [10:0] {
    XCR_OP_NONE = 11'h001,
    XCR_OP_USBCMD = 11'h002,
    XCR_OP_USBSTS = 11'h004,
    XCR_OP_PAGESIZE = 11'h008,
    XCR_OP_DNCTRL = 11'h010,
    XCR_OP_CRCR = 11'h020,
    XCR_OP_DCBAAP = 11'h040,
    XCR_OP_CONFIG = 11'h080,
    XCR_OP_PORT = 11'h100,
    XCR_OP_RSVD = 11'h200,
    XCR_OP_CAP = 11'h400
  } xcr_sel_e;

  // decoded access carried to the operational register owners
  typedef struct packed {
    xcr_sel_e sel;
    logic [15:0] op_off;
    logic wr;
    logic rd;
  } xcr_dec_s;

endpackage : xcr_pkg

/* sim/xcr_cap_regs_tb.sv */
module xcr_cap_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk;
  logic rst_n;
  logic req_rd;
  logic req_wr;
  logic [15:0] req_addr;
  logic port_power_absent_cfg;
  logic [31:0] rd_data;
  logic rd_valid;
  xcr_pkg::xcr_dec_s op_dec;
  int num_errors = 0;
  int compares = 0;
  logic p_rst;
  logic p_rd;
  logic p_wr;
  logic p_cfg;
  logic [15:0] p_a;
  xcr_pkg::xcr_sel_e p_sel;

  xcr_cap_regs dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_rd(req_rd),
    .req_wr(req_wr),
    .req_addr(req_addr),
    .port_power_absent_cfg(port_power_absent_cfg),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .op_dec(op_dec)
  );

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bit 3 follows the configuration level sampled with the read
  function automatic logic [31:0] exp_data(logic [15:0] a, logic cfg);
    case (a)
      16'h0000: return {24'h00_0000, xcr_pkg::CAP_LENGTH};
      16'h0010: return {16'h0270, 4'hf, 2'h0, 3'h0, 3'h6, cfg, 3'h5};
      16'h0014: return 32'h0000_05c0;
      16'h0018: return 32'h0000_04a0;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // operational offsets are taken from the bank base plus the length value
  function automatic xcr_pkg::xcr_sel_e exp_sel(logic [15:0] a);
    logic [15:0] op;
    op = a - 16'(xcr_pkg::CAP_LENGTH);
    if (a < 16'(xcr_pkg::CAP_LENGTH)) return xcr_pkg::XCR_OP_CAP;
    case (op) inside
      16'h0000: return xcr_pkg::XCR_OP_USBCMD;
      16'h0004: return xcr_pkg::XCR_OP_USBSTS;
      16'h0008: return xcr_pkg::XCR_OP_PAGESIZE;
      16'h0014: return xcr_pkg::XCR_OP_DNCTRL;
      [16'h0018:16'h001f]: return xcr_pkg::XCR_OP_CRCR;
      [16'h0030:16'h0037]: return xcr_pkg::XCR_OP_DCBAAP;
      16'h0038: return xcr_pkg::XCR_OP_CONFIG;
      [16'h0400:16'h047f]: return xcr_pkg::XCR_OP_PORT;
      default: return xcr_pkg::XCR_OP_RSVD;
    endcase
  endfunction

  // one access per edge, so back-to-back traffic comes for free
  task automatic drive(logic r, logic w, logic [15:0] a, logic cfg);
    @(posedge ref_clk);
    req_rd <= r;
    req_wr <= w;
    req_addr <= a;
    port_power_absent_cfg <= cfg;
  endtask

  // monitor: every answer is judged 1 ns after the edge that took it
  always @(posedge ref_clk) begin
    p_rst = rst_n;
    p_rd = req_rd;
    p_wr = req_wr;
    p_a = req_addr;
    p_cfg = port_power_absent_cfg;
    #1;
    if (p_rst && rst_n) begin
      check("rd_valid", 32'(rd_valid), 32'(p_rd));
      if (p_rd) check("rd_data", rd_data, exp_data(p_a, p_cfg));
      // field by field, so a wrong flag is named by what it advertises
      if (p_rd && p_a == 16'h0010) begin
        check("ext_cap_pointer", 32'(rd_data[31:16]), 32'h0000_0270);
        check("max_primary_stream_array", 32'(rd_data[15:12]), 32'h0000_000f);
        check("reserved", 32'(rd_data[11:10]), 32'h0000_0000);
        check("secondary_bw_domain_report", 32'(rd_data[9]), 32'h0000_0000);
        check("force_stopped_event_cap", 32'(rd_data[8]), 32'h0000_0000);
        check("no_secondary_stream_id", 32'(rd_data[7]), 32'h0000_0000);
        check("latency_tolerance_cap", 32'(rd_data[6]), 32'h0000_0001);
        check("light_reset_cap", 32'(rd_data[5]), 32'h0000_0001);
        check("port_indicator_cap", 32'(rd_data[4]), 32'h0000_0000);
        check("port_power_control_cap", 32'(rd_data[3]), 32'(p_cfg));
        check("context_size_flag", 32'(rd_data[2]), 32'h0000_0001);
        check("bw_negotiation_cap", 32'(rd_data[1]), 32'h0000_0000);
        check("wide_address_cap", 32'(rd_data[0]), 32'h0000_0001);
      end
      p_sel = (p_rd || p_wr) ? exp_sel(p_a) : xcr_pkg::XCR_OP_NONE;
      check("sel", 32'(op_dec.sel), 32'(p_sel));
      // idle cycles and refused regions must leave both strobes low
      if (!(p_rd || p_wr) || p_sel inside {xcr_pkg::XCR_OP_CAP, xcr_pkg::XCR_OP_RSVD}) begin
        check("wr", 32'(op_dec.wr), 32'h0000_0000);
        check("rd", 32'(op_dec.rd), 32'h0000_0000);
      end else begin
        check("op_off", 32'(op_dec.op_off), 32'(16'(p_a - 16'(xcr_pkg::CAP_LENGTH))));
        check("wr", 32'(op_dec.wr), 32'(p_wr));
        check("rd", 32'(op_dec.rd), 32'(p_rd));
      end
    end
  end

  // a stuck bench still reaches the verdict
  initial begin
    #1_000_000;
    num_errors++;
    finish_test();
  end

  initial begin
    int r;
    rst_n = 1'b0;
    req_rd = 1'b0;
    req_wr = 1'b0;
    req_addr = 16'h0000;
    port_power_absent_cfg = 1'b0;
    void'($urandom(93929));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // sweep every word of the bank and window, read then write, both levels of cfg
    for (int i = 0; i < 16'h0500; i += 4) begin
      drive(1'b1, 1'b0, 16'(i), i[3]);
      drive(1'b0, 1'b1, 16'(i), ~i[3]);
    end
    // power bit seen at both levels, back to back on the parameter word
    drive(1'b1, 1'b0, 16'h0010, 1'b1);
    drive(1'b1, 1'b0, 16'h0010, 1'b0);
    drive(1'b1, 1'b0, 16'h0010, 1'b1);
    // reset lands on the edge that takes a read, so its answer must never show
    drive(1'b1, 1'b0, 16'h0010, 1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    req_rd <= 1'b0;
    #1;
    check("rst_valid", 32'(rd_valid), 32'h0000_0000);
    check("rst_data", rd_data, 32'h0000_0000);
    check("rst_sel", 32'(op_dec.sel), 32'(xcr_pkg::XCR_OP_NONE));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // random mix of reads, writes and idles across the whole address space
    for (int n = 0; n < 2000; n++) begin
      r = $urandom_range(0, 2);
      drive(r == 0, r == 1, 16'($urandom_range(0, 3) == 0 ? $urandom : $urandom_range(0, 16'h04ff))
            & 16'hfffc, 1'($urandom_range(0, 1)));
    end
    drive(1'b0, 1'b0, 16'h0000, 1'b0);
    @(posedge ref_clk);
    @(posedge ref_clk);
    finish_test();
  end
endmodule : xcr_cap_regs_tb

/* verilog/xcr_cap_regs.sv */
// What this block does
// - capability parameters bits 31:16 read 0270h, first extended capability at 09C0h.
// - bits 15:12 read 1111, primary stream array up to 64K entries.
// - reserved bits 11:10 always read zero.
// - bit 9 reads 0, no secondary bandwidth domain reporting.
// - bit 8 reads 0, no force-stopped events.
// - bit 7 reads 0, secondary stream id decoding supported.
// - bit 6 reads 1, latency tolerance messaging supported.
// - bit 5 reads 1, light controller reset supported.
// - bit 4 reads 0, no port indicator control.
// - bit 3 follows the port power absent configuration bit.
// - bit 2 reads 1, 64-byte context structures.
// - bit 1 reads 0, no bandwidth negotiation.
// - bit 0 reads 1, 64-bit address pointers.
// - word at 14h always reads 0000 05C0h, doorbell array offset.
// - word at 18h always reads 0000 04A0h, runtime space offset.
// - operational base equals bank base plus capability length.
// - decode command 00h, status 04h, page size 08h, notification 14h.
// - decode command ring words 18h and 1Ch and context array pointer words 30h and 34h.
// - port register sets 1-8 occupy operational 400h-47Fh.
module xcr_cap_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // memory access, byte address relative to the bank base
  input wire logic req_rd,
  input wire logic req_wr,
  input wire logic [15:0] req_addr,
  // configuration from the control register elsewhere
  input wire logic port_power_absent_cfg,
  // read data of this bank
  output logic [31:0] rd_data,
  output logic rd_valid,
  // decoded operational access
  output xcr_pkg::xcr_dec_s op_dec
);

  logic [31:0] cap_params;
  logic [31:0] cap_word;
  logic cap_hit;
  logic [15:0] op_off;
  logic op_hit;
  xcr_pkg::xcr_sel_e sel;
  logic [31:0] rd_data_next;

  // capability parameters word, built from named fields
  always_comb begin
    cap_params = {xcr_pkg::EXT_CAP_PTR,
                  xcr_pkg::MAX_PSA,
                  xcr_pkg::CAP_RSVD,
                  xcr_pkg::SEC_BW_DOMAIN,
                  xcr_pkg::FORCE_STOP,
                  xcr_pkg::NO_SEC_SID,
                  xcr_pkg::LAT_TOL,
                  xcr_pkg::LIGHT_RESET,
                  xcr_pkg::PORT_IND,
                  port_power_absent_cfg,
                  xcr_pkg::CTX_SIZE_64,
                  xcr_pkg::BW_NEG,
                  xcr_pkg::WIDE_ADDR};
  end

  // operational offset is the address less the capability length
  assign op_hit = req_addr >= {8'h00, xcr_pkg::CAP_LENGTH};
  assign op_off = req_addr - {8'h00, xcr_pkg::CAP_LENGTH};

  // capability word mux; unmapped capability words read zero
  always_comb begin
    cap_hit = 1'b1;
    case (req_addr)
      xcr_pkg::CAPLEN_OFF: cap_word = {24'h00_0000, xcr_pkg::CAP_LENGTH};
      xcr_pkg::CAP_PARAMS_OFF: cap_word = cap_params;
      xcr_pkg::DOORBELL_OFF: cap_word = xcr_pkg::DOORBELL_VAL;
      xcr_pkg::RUNTIME_OFF: cap_word = xcr_pkg::RUNTIME_VAL;
      default: begin
        cap_word = 32'h0000_0000;
        cap_hit = 1'b0;
      end
    endcase
  end

  // operational region select; the register owners act only on their own select
  always_comb begin
    if (!op_hit) begin
      sel = xcr_pkg::XCR_OP_CAP;
    end else if (op_off == xcr_pkg::OP_USBCMD) begin
      sel = xcr_pkg::XCR_OP_USBCMD;
    end else if (op_off == xcr_pkg::OP_USBSTS) begin
      sel = xcr_pkg::XCR_OP_USBSTS;
    end else if (op_off == xcr_pkg::OP_PAGESIZE) begin
      sel = xcr_pkg::XCR_OP_PAGESIZE;
    end else if (op_off == xcr_pkg::OP_DNCTRL) begin
      sel = xcr_pkg::XCR_OP_DNCTRL;
    end else if (op_off == xcr_pkg::OP_CRCR_LO || op_off == xcr_pkg::OP_CRCR_HI) begin
      sel = xcr_pkg::XCR_OP_CRCR;
    end else if (op_off == xcr_pkg::OP_DCBAAP_LO || op_off == xcr_pkg::OP_DCBAAP_HI) begin
      sel = xcr_pkg::XCR_OP_DCBAAP;
    end else if (op_off == xcr_pkg::OP_CONFIG) begin
      sel = xcr_pkg::XCR_OP_CONFIG;
    end else if (op_off >= xcr_pkg::OP_PORT_LO && op_off <= xcr_pkg::OP_PORT_HI) begin
      sel = xcr_pkg::XCR_OP_PORT;
    end else begin
      sel = xcr_pkg::XCR_OP_RSVD;
    end
  end

  // read data; writes into capability or reserved space fall through untouched
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (req_rd && !op_hit && cap_hit) begin
      rd_data_next = cap_word;
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= rd_data_next;
      rd_valid <= req_rd;
    end
  end

  // registered operational decode; reserved and capability writes carry no strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_dec <= '{sel: xcr_pkg::XCR_OP_NONE, op_off: 16'h0000, wr: 1'b0, rd: 1'b0};
    end else if (req_rd || req_wr) begin
      op_dec.sel <= sel;
      op_dec.op_off <= op_off;
      op_dec.wr <= req_wr && sel != xcr_pkg::XCR_OP_CAP && sel != xcr_pkg::XCR_OP_RSVD;
      op_dec.rd <= req_rd && sel != xcr_pkg::XCR_OP_CAP && sel != xcr_pkg::XCR_OP_RSVD;
    end else begin
      op_dec.sel <= xcr_pkg::XCR_OP_NONE;
      op_dec.wr <= 1'b0;
      op_dec.rd <= 1'b0;
    end
  end

  // parameter word matches its fixed fields and the live power bit
  property p_cap_read;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == xcr_pkg::CAP_PARAMS_OFF |=>
        rd_valid && rd_data[31:4] == 28'h027_0f06 && rd_data[2:0] == 3'h5
        && rd_data[3] == $past(port_power_absent_cfg);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability word wrong");

  property p_psa;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == xcr_pkg::CAP_PARAMS_OFF |=> rd_data[15:10] == 6'h3c;
  endproperty
  a_psa: assert property (p_psa) else $error("stream size or reserved wrong");

  property p_power_ctl;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == xcr_pkg::CAP_PARAMS_OFF && port_power_absent_cfg |=> rd_data[3];
  endproperty
  a_power_ctl: assert property (p_power_ctl) else $error("power control bit wrong");

  property p_db;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == xcr_pkg::DOORBELL_OFF |=> rd_data == 32'h0000_05c0;
  endproperty
  a_db: assert property (p_db) else $error("doorbell offset wrong");

  property p_rt;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == xcr_pkg::RUNTIME_OFF |=> rd_data == 32'h0000_04a0;
  endproperty
  a_rt: assert property (p_rt) else $error("runtime offset wrong");

  property p_cmd;
    @(posedge ref_clk) disable iff (!rst_n)
      req_wr && req_addr == 16'h0020 |=> op_dec.sel == xcr_pkg::XCR_OP_USBCMD && op_dec.wr;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command decode wrong");

  property p_crcr;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h003c |=> op_dec.sel == xcr_pkg::XCR_OP_CRCR;
  endproperty
  a_crcr: assert property (p_crcr) else $error("ring control decode wrong");

  property p_port;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h049c |=> op_dec.sel == xcr_pkg::XCR_OP_PORT;
  endproperty
  a_port: assert property (p_port) else $error("port decode wrong");

  property p_rsvd_wr;
    @(posedge ref_clk) disable iff (!rst_n)
      req_wr && (req_addr == 16'h0010 || req_addr == 16'h002c) |=> !op_dec.wr;
  endproperty
  a_rsvd_wr: assert property (p_rsvd_wr) else $error("write leaked");

  // each flag of the parameter word on its own, the power bit only at its low level, so a failure names the field
  property p_rsvd_bits;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> rd_data[11:10] == 2'h0;
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bits set");

  property p_sec_bw;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> !rd_data[9];
  endproperty
  a_sec_bw: assert property (p_sec_bw) else $error("secondary bandwidth bit set");

  property p_force_stop;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> !rd_data[8];
  endproperty
  a_force_stop: assert property (p_force_stop) else $error("force stop bit set");

  property p_sec_sid;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> !rd_data[7];
  endproperty
  a_sec_sid: assert property (p_sec_sid) else $error("secondary stream bit set");

  property p_lat_tol;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> rd_data[6];
  endproperty
  a_lat_tol: assert property (p_lat_tol) else $error("latency tolerance bit clear");

  property p_light_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> rd_data[5];
  endproperty
  a_light_reset: assert property (p_light_reset) else $error("light reset bit clear");

  property p_port_ind;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> !rd_data[4];
  endproperty
  a_port_ind: assert property (p_port_ind) else $error("port indicator bit set");

  property p_power_ctl_off;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 && !port_power_absent_cfg |=> !rd_data[3];
  endproperty
  a_power_ctl_off: assert property (p_power_ctl_off) else $error("power bit set");

  property p_ctx_size;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> rd_data[2];
  endproperty
  a_ctx_size: assert property (p_ctx_size) else $error("context size bit clear");

  property p_bw_neg;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> !rd_data[1];
  endproperty
  a_bw_neg: assert property (p_bw_neg) else $error("bandwidth negotiation bit set");

  property p_wide_addr;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0010 |=> rd_data[0];
  endproperty
  a_wide_addr: assert property (p_wide_addr) else $error("wide address bit clear");

  // decode of every operational region except command and command ring, counted from the base plus the length value
  property p_cap_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_rd || req_wr) && req_addr < 16'h0020 |=> op_dec.sel == xcr_pkg::XCR_OP_CAP;
  endproperty
  a_cap_sel: assert property (p_cap_sel) else $error("capability decode wrong");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0024 |=>
        op_dec.sel == xcr_pkg::XCR_OP_USBSTS && op_dec.rd && op_dec.op_off == 16'h0004;
  endproperty
  a_status: assert property (p_status) else $error("status decode wrong");

  property p_page_size;
    @(posedge ref_clk) disable iff (!rst_n)
      req_wr && req_addr == 16'h0028 |=> op_dec.sel == xcr_pkg::XCR_OP_PAGESIZE && op_dec.wr;
  endproperty
  a_page_size: assert property (p_page_size) else $error("page size decode wrong");

  property p_notify;
    @(posedge ref_clk) disable iff (!rst_n)
      req_rd && req_addr == 16'h0034 |=> op_dec.sel == xcr_pkg::XCR_OP_DNCTRL;
  endproperty
  a_notify: assert property (p_notify) else $error("notification decode wrong");

  property p_ctx_array;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_rd || req_wr) && (req_addr == 16'h0050 || req_addr == 16'h0054) |=>
        op_dec.sel == xcr_pkg::XCR_OP_DCBAAP;
  endproperty
  a_ctx_array: assert property (p_ctx_array) else $error("context array decode wrong");

  property p_config;
    @(posedge ref_clk) disable iff (!rst_n)
      req_wr && req_addr == 16'h0058 |=> op_dec.sel == xcr_pkg::XCR_OP_CONFIG && op_dec.wr;
  endproperty
  a_config: assert property (p_config) else $error("configure decode wrong");

  property p_rsvd_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_rd || req_wr) && (req_addr == 16'h002c || req_addr == 16'h0040 || req_addr == 16'h005c
      || req_addr == 16'h041c) |=> op_dec.sel == xcr_pkg::XCR_OP_RSVD && !op_dec.wr && !op_dec.rd;
  endproperty
  a_rsvd_sel: assert property (p_rsvd_sel) else $error("reserved decode wrong");

  property p_port_lo;
    @(posedge ref_clk) disable iff (!rst_n)
      req_wr && req_addr == 16'h0420 |=> op_dec.sel == xcr_pkg::XCR_OP_PORT && op_dec.op_off == 16'h0400;
  endproperty
  a_port_lo: assert property (p_port_lo) else $error("port window start wrong");

  property p_port_end;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_rd || req_wr) && req_addr == 16'h04a0 |=> op_dec.sel == xcr_pkg::XCR_OP_RSVD;
  endproperty
  a_port_end: assert property (p_port_end) else $error("port window end wrong");

endmodule : xcr_cap_regs
